// File: hw/tmz_pkg.sv
// Constants and types shared by the timer0 counter unit.
// Assumes a single core clock and byte-wide register access strobes.
package tmz_pkg;
  localparam int unsigned CNT_W      = 8;
  localparam int unsigned PRE_W      = 15;
  localparam int unsigned SEL_W      = 4;
  localparam int unsigned SRC_N      = 8;
  // First control register layout
  localparam int unsigned C0_EN_BIT   = 7;
  localparam int unsigned C0_OUT_BIT  = 5;
  localparam int unsigned C0_WIDE_BIT = 4;
  localparam int unsigned C0_PS_LSB   = 0;
  // Second control register layout
  localparam int unsigned C1_CS_LSB    = 5;
  localparam int unsigned C1_ASYNC_BIT = 4;
  localparam int unsigned C1_CK_LSB    = 0;
  // Reset values and count constants
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [PRE_W-1:0] PRE_ZERO = 15'h0000;
  localparam logic [SEL_W-1:0] SEL_ZERO = 4'h0;
  localparam logic [15:0] CNT16_ALL1 = 16'hffff;
  localparam logic [15:0] CNT16_ONE  = 16'h0001;
  localparam logic [PRE_W-1:0] PRE_ONE = 15'h0001;
  localparam logic [SEL_W-1:0] SEL_ONE = 4'h1;

  typedef struct packed {
    logic             en;
    logic             wide;
    logic [SEL_W-1:0] outps;
    logic [2:0]       cs;
    logic             async_sel;
    logic [SEL_W-1:0] ckps;
  } tmz_ctrl_t;
endpackage

// File: hw/tmz_timer0.sv
// Timer0 counter unit: 8-bit period timer or 16-bit free-running counter.
// Assumes all inputs are synchronous to I_CORE_CLK and register strobes are one-cycle pulses.
`timescale 1ns/100ps

// What this block does
// - Width select picks 8-bit or 16-bit counting
// - Counter advances on each prescaled source edge
// - 8-bit mode compares low count to period copy
// - Match clears low count, reloads period copy
// - 16-bit low read latches counter high byte
// - High write buffers; 16-bit low write loads both bytes
// - 16-bit counter wraps to zero past all-ones
// - No automatic reload in 16-bit mode
// - Clock source chosen by source select field
// - Sync mode resynchronises prescaled clock to core
// - Sync mode counter stops during sleep
// - Async mode counts on edges, also during sleep
// - Sixteen prescale ratios, 1:1 up to 1:32768
// - Prescaler count hidden from software
// - Prescaler clears on low or control writes, reset
// - Output toggles per postscaled event; period zero high
// - Postscaler divides by select plus one, same clears
// - Flag sets on each toggle, enables interrupt, wakes only in async mode during sleep
// - Counter runs only while enable bit set
module tmz_timer0
  import tmz_pkg::*;
#(
  parameter int unsigned P_PRE_W = PRE_W
) (
  // Clock and reset
  input  wire logic             I_CORE_CLK,
  input  wire logic             I_RST,
  // Clock sources and power state
  input  wire logic [SRC_N-1:0] I_CLK_SRC,
  input  wire logic             I_SLEEP,
  // Register access
  input  wire logic [7:0]       I_WDATA,
  input  wire logic             I_WR_LOW,
  input  wire logic             I_WR_HIGH,
  input  wire logic             I_WR_CON0,
  input  wire logic             I_WR_CON1,
  input  wire logic             I_RD_LOW,
  // Interrupt control
  input  wire logic             I_INT_ENABLE,
  input  wire logic             I_FLAG_CLR,
  // Register readback
  output logic [7:0]            O_COUNT_LOW,
  output logic [7:0]            O_COUNT_HIGH_OR_PERIOD,
  output logic [7:0]            O_CON0,
  output logic [7:0]            O_CON1,
  // Timer events
  output logic                  O_TIMER_OUTPUT,
  output logic                  O_TIMER_INTERRUPT_FLAG,
  output logic                  O_IRQ,
  output logic                  O_WAKE
);

  tmz_ctrl_t         ctrl, next_ctrl;
  logic [7:0]        cnt_low, next_cnt_low;
  logic [7:0]        cnt_high, next_cnt_high;
  logic [7:0]        high_reg, next_high_reg;
  logic [7:0]        period_buf, next_period_buf;
  logic [P_PRE_W-1:0] pre_cnt, next_pre_cnt;
  logic [SEL_W-1:0]  post_cnt, next_post_cnt;
  logic              src_q, next_src_q, src_d, next_src_d;
  logic              sync_q, next_sync_q, sync_d, next_sync_d;
  logic              tout, next_tout;
  logic              flag, next_flag;
  logic              irq, next_irq;
  logic              wake, next_wake;

  logic              src_edge;
  logic              pre_tick;
  logic              sync_edge;
  logic              tick;
  logic              ev8, ev16, ev;
  logic              post_hit;
  logic              ctrl_wr;
  logic [P_PRE_W-1:0] pre_mask;
  logic [15:0]       cnt16, cnt16_inc;

  assign ctrl_wr = I_WR_CON0 | I_WR_CON1;
  assign cnt16   = {cnt_high, cnt_low};
  assign cnt16_inc = cnt16 + CNT16_ONE;
  // Division by two to the power n; bits above the counter width are dropped
  assign pre_mask = P_PRE_W'((PRE_ONE << ctrl.ckps) - PRE_ONE);
  assign src_edge = src_q & ~src_d;
  assign pre_tick = src_edge & ((pre_cnt & pre_mask) == pre_mask);
  assign sync_edge = sync_q & ~sync_d;
  // Async counts directly on the prescaled edge; sync goes through the core stage
  assign tick = ctrl.en & (ctrl.async_sel ? pre_tick : (sync_edge & ~I_SLEEP));
  assign ev8  = tick & ~ctrl.wide & (cnt_low == period_buf);
  assign ev16 = tick & ctrl.wide & (cnt16 == CNT16_ALL1);
  assign ev   = ev8 | ev16;
  assign post_hit = ev & (post_cnt == ctrl.outps);

  always_comb begin
    next_ctrl       = ctrl;
    next_cnt_low    = cnt_low;
    next_cnt_high   = cnt_high;
    next_high_reg   = high_reg;
    next_period_buf = period_buf;
    next_pre_cnt    = pre_cnt;
    next_post_cnt   = post_cnt;
    next_tout       = tout;
    next_flag       = flag;
    // Source selection and edge staging
    next_src_q  = I_CLK_SRC[ctrl.cs];
    next_src_d  = src_q;
    next_sync_q = pre_tick & ctrl.en;
    next_sync_d = sync_q;
    if (ctrl.en && src_edge) begin
      next_pre_cnt = pre_cnt + PRE_ONE;
    end
    // Counting
    if (tick) begin
      if (ctrl.wide) begin
        next_cnt_low  = cnt16_inc[7:0];
        next_cnt_high = cnt16_inc[15:8];
      end else if (cnt_low == period_buf) begin
        next_cnt_low    = RST_BYTE;
        next_period_buf = high_reg;
      end else begin
        next_cnt_low = cnt_low + 8'h01;
      end
    end
    // Postscaler, output and flag
    if (ev) begin
      next_post_cnt = post_hit ? SEL_ZERO : post_cnt + SEL_ONE;
    end
    if (post_hit) begin
      next_tout = (ev8 && period_buf == RST_BYTE) ? 1'b1 : ~tout;
    end
    if (I_FLAG_CLR) begin
      next_flag = 1'b0;
    end
    if (post_hit) begin
      next_flag = 1'b1;
    end
    // Register accesses
    if (I_RD_LOW && ctrl.wide) begin
      next_high_reg = cnt_high;
    end
    if (I_WR_HIGH) begin
      next_high_reg = I_WDATA;
    end
    if (I_WR_LOW) begin
      next_cnt_low = I_WDATA;
      if (ctrl.wide) begin
        next_cnt_high = high_reg;
      end
    end
    if (I_WR_CON0) begin
      next_ctrl.en    = I_WDATA[C0_EN_BIT];
      next_ctrl.wide  = I_WDATA[C0_WIDE_BIT];
      next_ctrl.outps = I_WDATA[C0_PS_LSB +: SEL_W];
    end
    if (I_WR_CON1) begin
      next_ctrl.cs        = I_WDATA[C1_CS_LSB +: 3];
      next_ctrl.async_sel = I_WDATA[C1_ASYNC_BIT];
      next_ctrl.ckps      = I_WDATA[C1_CK_LSB +: SEL_W];
    end
    if (I_WR_LOW || ctrl_wr) begin
      next_pre_cnt  = PRE_ZERO;
      next_post_cnt = SEL_ZERO;
    end
    next_irq  = next_flag & I_INT_ENABLE;
    next_wake = next_flag & I_INT_ENABLE & I_SLEEP & ctrl.async_sel;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ctrl       <= '0;
      cnt_low    <= RST_BYTE;
      cnt_high   <= RST_BYTE;
      high_reg   <= RST_BYTE;
      period_buf <= RST_BYTE;
      pre_cnt    <= '0;
      post_cnt   <= SEL_ZERO;
      src_q      <= 1'b0;
      src_d      <= 1'b0;
      sync_q     <= 1'b0;
      sync_d     <= 1'b0;
      tout       <= 1'b0;
      flag       <= 1'b0;
      irq        <= 1'b0;
      wake       <= 1'b0;
    end else begin
      ctrl       <= next_ctrl;
      cnt_low    <= next_cnt_low;
      cnt_high   <= next_cnt_high;
      high_reg   <= next_high_reg;
      period_buf <= next_period_buf;
      pre_cnt    <= next_pre_cnt;
      post_cnt   <= next_post_cnt;
      src_q      <= next_src_q;
      src_d      <= next_src_d;
      sync_q     <= next_sync_q;
      sync_d     <= next_sync_d;
      tout       <= next_tout;
      flag       <= next_flag;
      irq        <= next_irq;
      wake       <= next_wake;
    end
  end

  // Readback; prescaler and postscaler counts have no path out
  assign O_COUNT_LOW            = cnt_low;
  assign O_COUNT_HIGH_OR_PERIOD = high_reg;
  assign O_CON0 = {ctrl.en, 1'b0, tout, ctrl.wide, ctrl.outps};
  assign O_CON1 = {ctrl.cs, ctrl.async_sel, ctrl.ckps};
  assign O_TIMER_OUTPUT         = tout;
  assign O_TIMER_INTERRUPT_FLAG = flag;
  assign O_IRQ                  = irq;
  assign O_WAKE                 = wake;

  // Checks
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  AST_PRE_CLEAR: assert property ((I_WR_LOW || ctrl_wr) |=> pre_cnt == '0 && post_cnt == SEL_ZERO)
    else $error("prescaler or postscaler not cleared");
  AST_WRAP16: assert property (ev16 && !I_WR_LOW |=> cnt16 == 16'h0000)
    else $error("16-bit counter did not wrap");
  AST_MATCH8: assert property (ev8 && !I_WR_LOW && !I_WR_HIGH
                               |=> cnt_low == RST_BYTE && period_buf == $past(high_reg))
    else $error("8-bit match did not clear and reload");
  AST_RD_LATCH: assert property (I_RD_LOW && ctrl.wide && !I_WR_HIGH
                                 |=> high_reg == $past(cnt_high))
    else $error("low read did not latch high byte");
  AST_WR16: assert property (I_WR_LOW && ctrl.wide |=> cnt_high == $past(high_reg)
                             && cnt_low == $past(I_WDATA))
    else $error("16-bit write not coherent");
  AST_DISABLED: assert property (!ctrl.en |-> !tick)
    else $error("counting while disabled");
  AST_SLEEP_SYNC: assert property (I_SLEEP && !ctrl.async_sel |-> !tick)
    else $error("sync counter ran in sleep");
  AST_FLAG_WINS: assert property (post_hit && I_FLAG_CLR |=> flag)
    else $error("flag set lost to clear");
  AST_PERIOD0: assert property (ev8 && period_buf == RST_BYTE && post_hit |=> tout)
    else $error("zero period output not high");
  AST_IRQ: assert property (flag && I_INT_ENABLE && !I_FLAG_CLR |=> irq)
    else $error("interrupt not raised");
  AST_HOLD: assert property (!tick && !I_WR_LOW && !I_WR_HIGH |=> $stable(cnt_low))
    else $error("count changed without tick");

  // Counting and buffering
  AST_INC8: assert property (tick && !ctrl.wide && cnt_low != period_buf
                             && !I_WR_LOW |=> cnt_low == $past(cnt_low) + 8'h01)
    else $error("8-bit count did not advance");
  AST_INC16: assert property (tick && ctrl.wide && !I_WR_LOW
                              |=> cnt16 == $past(cnt16) + CNT16_ONE)
    else $error("16-bit count did not advance");
  AST_HIGH_HOLD: assert property (!tick && !I_WR_LOW |=> $stable(cnt_high))
    else $error("high byte reloaded without write");
  AST_PERIOD_HOLD: assert property (!ev8 |=> $stable(period_buf))
    else $error("period copy changed without match");
  AST_HIGH_BUF: assert property (I_WR_HIGH |=> high_reg == $past(I_WDATA))
    else $error("high write not buffered");
  AST_LOW_WR: assert property (I_WR_LOW |=> cnt_low == $past(I_WDATA))
    else $error("low write lost");

  // Prescaler and clock staging
  AST_PRE_STEP: assert property (ctrl.en && src_edge && !I_WR_LOW && !ctrl_wr
                                 |=> pre_cnt == $past(pre_cnt) + PRE_ONE)
    else $error("prescaler did not step");
  AST_PRE_FREEZE: assert property (!ctrl.en && !I_WR_LOW && !ctrl_wr
                                   |=> $stable(pre_cnt))
    else $error("prescaler ran while disabled");
  AST_PRE_DIRECT: assert property (ctrl.ckps == SEL_ZERO |-> pre_tick == src_edge)
    else $error("1:1 prescale skipped an edge");
  AST_SYNC_GAP: assert property (tick && !ctrl.async_sel && !I_WR_CON1 |=> !tick)
    else $error("sync count faster than core stage");
  AST_ASYNC_DIRECT: assert property (ctrl.en && ctrl.async_sel |-> tick == pre_tick)
    else $error("async count not on prescaled edge");
  AST_SRC_SAMPLE: assert property (1'b1 |=> src_q == $past(I_CLK_SRC[ctrl.cs]))
    else $error("wrong clock source sampled");

  // Output, postscaler and flag
  AST_POST_STEP: assert property (ev && !post_hit && !I_WR_LOW && !ctrl_wr
                                  |=> post_cnt == $past(post_cnt) + SEL_ONE)
    else $error("postscaler did not step");
  AST_POST_WRAP: assert property (post_hit |=> post_cnt == SEL_ZERO)
    else $error("postscaler not cleared on output event");
  AST_TOGGLE: assert property (post_hit && !(ev8 && period_buf == RST_BYTE)
                               |=> tout != $past(tout))
    else $error("output did not toggle");
  AST_OUT_HOLD: assert property (!post_hit |=> $stable(tout))
    else $error("output changed without event");
  AST_FLAG_SET: assert property (post_hit |=> flag)
    else $error("flag not set on output event");
  AST_FLAG_CLR: assert property (I_FLAG_CLR && !post_hit |=> !flag)
    else $error("flag not cleared");
  AST_IRQ_OFF: assert property (!I_INT_ENABLE |=> !irq)
    else $error("interrupt without enable");
  AST_WAKE_GATE: assert property (!I_SLEEP || !ctrl.async_sel |=> !wake)
    else $error("wake outside async sleep");

  // Control writes
  AST_CON1_WR: assert property (I_WR_CON1 |=> O_CON1 == $past(I_WDATA))
    else $error("second control write lost");
  AST_WIDE_WR: assert property (I_WR_CON0 |=> ctrl.wide == $past(I_WDATA[C0_WIDE_BIT]))
    else $error("width select write lost");
  AST_EN_WR: assert property (I_WR_CON0 |=> ctrl.en == $past(I_WDATA[C0_EN_BIT]))
    else $error("enable write lost");

  COV_MATCH8: cover property (ev8 && period_buf != RST_BYTE);
  COV_SYNC_TICK: cover property (tick && !ctrl.async_sel && !I_SLEEP);
  COV_WRAP16: cover property (ev16);
  COV_TOGGLE: cover property (post_hit && ctrl.outps != SEL_ZERO);
  COV_ASYNC_SLEEP: cover property (tick && I_SLEEP);

endmodule

// File: tb/tb_tmz_timer0.sv
// Self-checking bench for the timer0 counter unit.
// Assumes the design asserts its own rules internally; stimulus at falling clock edges.
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_tmz_timer0;
  import tmz_pkg::*;
  localparam int K_LOW = 0;
  localparam int K_HIGH = 1;
  localparam int K_CON0 = 2;
  localparam int K_CON1 = 3;
  localparam int K_FCLR = 4;
  localparam int K_RD = 5;
  logic             clk;
  logic             rst;
  logic [SRC_N-1:0] src;
  logic             sleep;
  logic [7:0]       wdata;
  logic [5:0]       wstb;
  logic             int_en;
  logic [7:0]       cnt_low;
  logic [7:0]       cnt_high;
  logic [7:0]       con0;
  logic [7:0]       con1;
  logic             tout;
  logic             flag;
  logic             irq;
  logic             wake;
  int               errors;
  int               n_compared;

  tmz_timer0 dut (
    .I_CORE_CLK             (clk),
    .I_RST                  (rst),
    .I_CLK_SRC              (src),
    .I_SLEEP                (sleep),
    .I_WDATA                (wdata),
    .I_WR_LOW               (wstb[K_LOW]),
    .I_WR_HIGH              (wstb[K_HIGH]),
    .I_WR_CON0              (wstb[K_CON0]),
    .I_WR_CON1              (wstb[K_CON1]),
    .I_RD_LOW               (wstb[K_RD]),
    .I_INT_ENABLE           (int_en),
    .I_FLAG_CLR             (wstb[K_FCLR]),
    .O_COUNT_LOW            (cnt_low),
    .O_COUNT_HIGH_OR_PERIOD (cnt_high),
    .O_CON0                 (con0),
    .O_CON1                 (con1),
    .O_TIMER_OUTPUT         (tout),
    .O_TIMER_INTERRUPT_FLAG (flag),
    .O_IRQ                  (irq),
    .O_WAKE                 (wake)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // One-cycle strobe with data, then one idle cycle so readbacks settle
  task automatic stb(input int k, input logic [7:0] d);
    wdata = d;
    wstb[k] = 1'b1;
    @(negedge clk);
    wstb = 6'h00;
    @(negedge clk);
  endtask

  // One full source pulse, high and low three core cycles each
  task automatic pulse(input int s);
    src[s] = 1'b1;
    repeat (3) @(negedge clk);
    src[s] = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic stop_test();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    errors = 0;
    n_compared = 0;
    rst = 1'b1;
    src = 8'h00;
    sleep = 1'b0;
    wdata = 8'h00;
    wstb = 6'h00;
    int_en = 1'b0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    `CHK({cnt_low, cnt_high, con0, con1}, 32'h0000_0000)
    `CHK({tout, flag, irq, wake}, 4'h0)
    // Control readback, then 8-bit mode with period 2
    stb(K_CON1, 8'he5);
    `CHK(con1, 8'he5)
    stb(K_CON1, 8'h00);
    stb(K_CON0, 8'h80);
    `CHK(con0, 8'h80)
    stb(K_HIGH, 8'h02);
    int_en = 1'b1;
    pulse(0);
    `CHK({cnt_low, tout, flag}, 10'h003)
    `CHK(irq, 1'b1)
    `CHK(cnt_high, 8'h02)
    stb(K_FCLR, 8'h00);
    `CHK(flag, 1'b0)
    pulse(0);
    `CHK(cnt_low, 8'h01)
    pulse(0);
    `CHK({cnt_low, tout, flag}, 10'h00a)
    pulse(0);
    `CHK({cnt_low, tout, flag}, 10'h001)
    // 16-bit mode: buffered high write, rollover, coherent read
    stb(K_CON0, 8'h90);
    stb(K_FCLR, 8'h00);
    stb(K_HIGH, 8'hff);
    stb(K_LOW, 8'hfe);
    `CHK(cnt_low, 8'hfe)
    pulse(0);
    `CHK({cnt_low, flag}, 9'h1fe)
    pulse(0);
    `CHK({cnt_low, flag}, 9'h001)
    stb(K_RD, 8'h00);
    `CHK(cnt_high, 8'h00)
    pulse(0);
    `CHK(cnt_low, 8'h01)
    // Prescale 1:2, and its clear on a low write
    stb(K_CON1, 8'h01);
    pulse(0);
    `CHK(cnt_low, 8'h01)
    pulse(0);
    `CHK(cnt_low, 8'h02)
    `CHK(con1, 8'h01)
    pulse(0);
    stb(K_LOW, 8'h05);
    pulse(0);
    `CHK(cnt_low, 8'h05)
    pulse(0);
    `CHK(cnt_low, 8'h06)
    // Source select: only input 1 counts
    stb(K_CON1, 8'h20);
    pulse(0);
    `CHK(cnt_low, 8'h06)
    pulse(1);
    `CHK(cnt_low, 8'h07)
    // Sleep halts sync mode, async keeps counting and wakes
    sleep = 1'b1;
    pulse(1);
    `CHK(cnt_low, 8'h07)
    stb(K_CON1, 8'h30);
    pulse(1);
    `CHK(cnt_low, 8'h08)
    `CHK(wake, 1'b1)
    sleep = 1'b0;
    // Disabled module does not count
    stb(K_CON0, 8'h10);
    pulse(1);
    `CHK(cnt_low, 8'h08)
    // Postscaler 1:2 on an 8-bit period, and the sync latency
    stb(K_CON1, 8'h20);
    stb(K_CON0, 8'h81);
    stb(K_HIGH, 8'h01);
    stb(K_LOW, 8'h00);
    stb(K_FCLR, 8'h00);
    `CHK({flag, irq}, 2'b00)
    src[1] = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(cnt_low, 8'h00)
    @(negedge clk);
    `CHK(cnt_low, 8'h01)
    src[1] = 1'b0;
    repeat (3) @(negedge clk);
    pulse(1);
    pulse(1);
    `CHK({cnt_low, tout, flag}, 10'h002)
    pulse(1);
    pulse(1);
    `CHK({cnt_low, tout, flag}, 10'h001)
    stop_test();
  end
endmodule
